/* dv/pcs_clk_synth_cfg_tb.sv */
`timescale 1ns/1ns
module pcs_clk_synth_cfg_tb;
  reg ref_clk = 0, sys_rst = 1, seqWrite = 0;
  reg [7:0] seqIndex = 8'h00, seqWrData = 8'h00, d;
  reg [1:0] clockSelect = 2'h0;
  reg [27:0] numTab = {7'h66, 7'h5B, 7'h45, 7'h7E};
  wire [6:0] vclk0Numerator = 7'h66, vclk1Numerator = 7'h5B, vclk2Numerator = 7'h45, vclk3Numerator = 7'h7E;
  wire [7:0] seqRdData;
  wire [6:0] vclkNumerator;
  wire [4:0] vclkDenom;
  wire [5:0] mclkFactor;
  wire seqRdHit, vclkPostDiv2, vclkOscDouble, mclkOverride;
  integer fails = 0, total_checks = 0, cyc = 0, i;
  always #20 ref_clk = ~ref_clk;
  pcs_clk_synth_cfg dut_u (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .seqIndex(seqIndex),
    .seqWrite(seqWrite),
    .seqWrData(seqWrData),
    .seqRdData(seqRdData),
    .seqRdHit(seqRdHit),
    .vclk0Numerator(vclk0Numerator),
    .vclk1Numerator(vclk1Numerator),
    .vclk2Numerator(vclk2Numerator),
    .vclk3Numerator(vclk3Numerator),
    .clockSelect(clockSelect),
    .vclkNumerator(vclkNumerator),
    .vclkDenom(vclkDenom),
    .vclkPostDiv2(vclkPostDiv2),
    .vclkOscDouble(vclkOscDouble),
    .mclkFactor(mclkFactor),
    .mclkOverride(mclkOverride)
  );
  task chk(input [47:0] n, input [7:0] e, g);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("CHECK FAILED %0s expected %h seen %h", n, e, g);
      end
    end
  endtask
  task wr(input [7:0] idx, dat);
    begin
      @(posedge ref_clk) begin seqIndex <= idx; seqWrData <= dat; seqWrite <= 1'b1; end
      @(posedge ref_clk) seqWrite <= 1'b0;
    end
  endtask
  task rd(input [7:0] idx, e);
    begin
      @(posedge ref_clk) seqIndex <= idx;
      @(negedge ref_clk) chk("rdata", e, seqRdData);
      chk("hit", {7'h00, idx >= 8'h1B && idx <= 8'h1F}, {7'h00, seqRdHit});
    end
  endtask
  task test_reset_values;
    begin
      rd(8'h1B, 8'h3B);
      rd(8'h1C, 8'h2F);
      rd(8'h1D, 8'h30);
      rd(8'h1E, 8'h33);
      rd(8'h1A, 8'h00);
      chk("denom", 8'h1D, {3'h0, vclkDenom});
      chk("ovr", 8'h00, {7'h00, mclkOverride});
      $display("test_reset_values done");
    end
  endtask
  task test_dividers;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        d = 8'hC0 + 8'h15 * i[7:0];
        @(posedge ref_clk) clockSelect <= i[1:0];
        wr(8'h1B + i[7:0], d);
        @(posedge ref_clk);
        @(negedge ref_clk);
        chk("denom", {3'h0, d[5:1]}, {3'h0, vclkDenom});
        chk("post", {6'h00, d[0], d[0]}, {6'h00, vclkPostDiv2, vclkOscDouble});
        chk("numer", {1'b0, numTab[27 - 7 * i -: 7]}, {1'b0, vclkNumerator});
        rd(8'h1B + i[7:0], d & 8'h3F);
      end
      $display("test_dividers done");
    end
  endtask
  task test_mclk;
    begin
      wr(8'h1F, 8'hDC);
      @(posedge ref_clk);
      @(negedge ref_clk) chk("mclk", 8'h9C, {mclkOverride, 1'b0, mclkFactor});
      wr(8'h20, 8'hFF);
      rd(8'h20, 8'h00);
      rd(8'h1F, 8'h1C);
      $display("test_mclk done");
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 500) begin
      fails = fails + 1;
      give_verdict;
    end
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    test_reset_values;
    test_dividers;
    test_mclk;
    give_verdict;
  end
endmodule // pcs_clk_synth_cfg_tb

/* dv/pcs_synth_cfg_props.sv */
`timescale 1ns/1ns
module pcs_synth_cfg_props (
  // Port side
  input wire ref_clk, sys_rst, seqWrite, seqRdHit, vclkPostDiv2, vclkOscDouble, mclkOverride,
  input wire [7:0] seqIndex, seqWrData, seqRdData,
  input wire [6:0] vclk0Numerator, vclk1Numerator, vclk2Numerator, vclk3Numerator, vclkNumerator,
  input wire [1:0] clockSelect,
  input wire [4:0] vclkDenom,
  input wire [5:0] mclkFactor
);
  wire [6:0] selNum = clockSelect[1] ? (clockSelect[0] ? vclk3Numerator : vclk2Numerator) :
    (clockSelect[0] ? vclk1Numerator : vclk0Numerator);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_write_readback: assert property (seqWrite && seqRdHit ##1 $stable(seqIndex) |->
    seqRdData == (8'h3F & $past(seqWrData))) else $error("bad readback");
  a_miss_zero: assert property (!seqRdHit |-> seqRdData == 8'h00) else $error("miss not zero");
  a_hit_decode: assert property (seqRdHit == (seqIndex >= 8'h1B && seqIndex <= 8'h1F))
    else $error("bad decode");
  a_num_follow: assert property (1'b1 |=> vclkNumerator == $past(selNum)) else $error("bad numerator");
  a_denom_track: assert property (seqWrite && seqIndex == 8'h1B + clockSelect ##1 $stable(clockSelect) |=>
    vclkDenom == $past(seqWrData[5:1], 2) && vclkPostDiv2 == $past(seqWrData[0], 2)) else $error("bad denom");
  a_osc_double: assert property (vclkOscDouble == vclkPostDiv2) else $error("bad doubling");
  a_mclk_write: assert property (seqWrite && seqIndex == 8'h1F |=> ##1
    mclkFactor == $past(seqWrData[5:0], 2) && mclkOverride) else $error("bad mclk");
  a_override_sticky: assert property (mclkOverride |=> mclkOverride) else $error("override lost");
endmodule // pcs_synth_cfg_props
bind pcs_clk_synth_cfg pcs_synth_cfg_props u_props (.*);

/* logic/pcs_clk_ratio.v */
`timescale 1ns/1ns
`include "pcs_clk_regs.vh"
// Splits a divider register into synthesizer settings
module pcs_clk_ratio (
  // Register image
  input wire [7:0] divReg,
  // Synthesizer settings
  output wire [4:0] denom,
  output wire postDiv2,
  output wire oscDouble
);
  assign denom = divReg[`PCS_DEN_HI:`PCS_DEN_LO];
  assign postDiv2 = divReg[`PCS_POST_BIT];
  assign oscDouble = divReg[`PCS_POST_BIT];
endmodule // pcs_clk_ratio

/* logic/pcs_clk_regs.vh */
`ifndef PCS_CLK_REGS_VH
`define PCS_CLK_REGS_VH
// Sequencer indices reached through the data port
`define PCS_IDX_VCLK0_DIV 8'h1B
`define PCS_IDX_VCLK1_DIV 8'h1C
`define PCS_IDX_VCLK2_DIV 8'h1D
`define PCS_IDX_VCLK3_DIV 8'h1E
`define PCS_IDX_MCLK_FACTOR 8'h1F
// Field layout of a divider register
`define PCS_DEN_HI 5
`define PCS_DEN_LO 1
`define PCS_POST_BIT 0
`define PCS_WR_MASK 8'h3F
// Reset values of dividers, numerators and the memory clock factor
`define PCS_DIV0_RST 8'h3B
`define PCS_DIV1_RST 8'h2F
`define PCS_DIV2_RST 8'h30
`define PCS_DIV3_RST 8'h33
`define PCS_NUM0_RST 7'h66
`define PCS_NUM1_RST 7'h5B
`define PCS_NUM2_RST 7'h45
`define PCS_NUM3_RST 7'h7E
`define PCS_MCLK_RST 6'h19
// Settings image of clock 0, which is selected while reset is held
`define PCS_DEN0_RST 5'h1D
`define PCS_POST0_RST 1'b1
// Memory factor field and the divider slot code for a non-divider index
`define PCS_MCLK_HI 5
`define PCS_NO_SLOT 3'h4
// Memory clock reference divisor, as a shift
`define PCS_MCLK_SHIFT 3
`endif

/* logic/pcs_clk_synth_cfg.v */
// What this block does
// - Four video clock divider registers at indices 1B to 1E on the data port.
// - Clock-select field of the output register picks the active video clock.
// - Video clock is reference times numerator over denominator times post-scale.
// - Numerator comes from the seven-bit field of each numerator register.
// - Denominator is a five-bit field in bits 5 to 1.
// - Denominator excludes the post-scaler bit and is right-aligned.
// - Bit 0 is the post-scaler: zero divides by one, one by two.
// - With post-scaler set, the synthesizer oscillator runs at twice reference.
// - Dividers 0 to 2 reset to 3Bh, 2Fh, 30h; numerators 66h, 5Bh, 45h.
// - Divider 3 resets to 33h with numerator 7Eh.
// - Index 1F holds a six-bit memory clock factor overriding the preset.
// - Memory clock is reference over eight times the factor.
`timescale 1ns/1ns
`include "pcs_clk_regs.vh"
module pcs_clk_synth_cfg (
  // Clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // Sequencer data port access, index already latched
  input wire [7:0] seqIndex,
  input wire seqWrite,
  input wire [7:0] seqWrData,
  output wire [7:0] seqRdData,
  output wire seqRdHit,
  // Numerator registers and clock-select field held elsewhere
  input wire [6:0] vclk0Numerator,
  input wire [6:0] vclk1Numerator,
  input wire [6:0] vclk2Numerator,
  input wire [6:0] vclk3Numerator,
  input wire [1:0] clockSelect,
  // Active video clock synthesizer settings
  output reg [6:0] vclkNumerator,
  output reg [4:0] vclkDenom,
  output reg vclkPostDiv2,
  output reg vclkOscDouble,
  // Memory clock synthesizer settings
  output reg [5:0] mclkFactor,
  output reg mclkOverride
);
  reg [7:0] divReg [0:3];
  reg [5:0] mclkFactor_reg;
  reg [1:0] selIdx;
  wire [4:0] denomArr [0:3];
  wire [3:0] postArr;
  wire [3:0] dblArr;
  wire [6:0] numArr [0:3];
  reg [7:0] rdData;

  // Maps an index to its divider slot, 3'h4 when not a divider
  function [2:0] divSlot;
    input [7:0] idx;
    begin
      case (idx)
        `PCS_IDX_VCLK0_DIV: divSlot = 3'h0;
        `PCS_IDX_VCLK1_DIV: divSlot = 3'h1;
        `PCS_IDX_VCLK2_DIV: divSlot = 3'h2;
        `PCS_IDX_VCLK3_DIV: divSlot = 3'h3;
        default: divSlot = 3'h4;
      endcase
    end
  endfunction

  function [7:0] divReset;
    input integer n;
    begin
      case (n)
        2'h0: divReset = `PCS_DIV0_RST;
        2'h1: divReset = `PCS_DIV1_RST;
        2'h2: divReset = `PCS_DIV2_RST;
        default: divReset = `PCS_DIV3_RST;
      endcase
    end
  endfunction

  // True for the memory clock factor index
  function isFactorIdx;
    input [7:0] idx;
    begin
      isFactorIdx = (idx == `PCS_IDX_MCLK_FACTOR);
    end
  endfunction

  // Clears the two reserved upper bits of a divider image
  function [7:0] maskReserved;
    input [7:0] val;
    begin
      maskReserved = val & `PCS_WR_MASK;
    end
  endfunction

  assign numArr[0] = vclk0Numerator;
  assign numArr[1] = vclk1Numerator;
  assign numArr[2] = vclk2Numerator;
  assign numArr[3] = vclk3Numerator;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gDiv
      always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
          divReg[g] <= divReset(g);
        end else if (seqWrite && divSlot(seqIndex) == g) begin
          divReg[g] <= maskReserved(seqWrData);
        end
      end
      pcs_clk_ratio uRatio (
        .divReg(divReg[g]),
        .denom(denomArr[g]),
        .postDiv2(postArr[g]),
        .oscDouble(dblArr[g])
      );
    end
  endgenerate

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mclkFactor_reg <= `PCS_MCLK_RST;
    end else if (seqWrite && isFactorIdx(seqIndex)) begin
      mclkFactor_reg <= seqWrData[`PCS_MCLK_HI:0];
    end
  end

  // Settings follow writes two cycles later with no extra trigger
  always @* begin
    selIdx = clockSelect;
  end

  // Selected numerator, registered so the synthesizer sees a clean value
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      vclkNumerator <= `PCS_NUM0_RST;
    end else begin
      vclkNumerator <= numArr[selIdx];
    end
  end

  // Denominator of the selected clock, already right-aligned
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      vclkDenom <= `PCS_DEN0_RST;
    end else begin
      vclkDenom <= denomArr[selIdx];
    end
  end

  // Post-scaler and oscillator doubling travel together
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      vclkPostDiv2 <= `PCS_POST0_RST;
      vclkOscDouble <= `PCS_POST0_RST;
    end else begin
      vclkPostDiv2 <= postArr[selIdx];
      vclkOscDouble <= dblArr[selIdx];
    end
  end

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mclkFactor <= `PCS_MCLK_RST;
    end else begin
      mclkFactor <= mclkFactor_reg;
    end
  end

  // Once software writes the factor the coarse preset no longer applies
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mclkOverride <= 1'b0;
    end else if (seqWrite && isFactorIdx(seqIndex)) begin
      mclkOverride <= 1'b1;
    end
  end

  wire [2:0] rdSlot = divSlot(seqIndex);

  // Read path: divider slots first, then the factor, anything else reads zero
  always @* begin
    rdData = 8'h00;
    if (rdSlot != `PCS_NO_SLOT) begin
      rdData = maskReserved(divReg[rdSlot[1:0]]);
    end else if (isFactorIdx(seqIndex)) begin
      rdData = {2'h0, mclkFactor_reg};
    end
  end

  assign seqRdHit = (rdSlot != `PCS_NO_SLOT) || isFactorIdx(seqIndex);
  assign seqRdData = rdData;
endmodule // pcs_clk_synth_cfg
